// ==== inc/ppd_pkg.sv ====
// Package: constants, codes and register map of the eight-pin port block
package ppd_pkg;

    localparam int NPINS = 8;
    localparam int NAUX  = 16;
    localparam int AW    = 5;

    typedef enum logic [2:0] {
        DM_ANALOG  = 3'h0,
        DM_DIGIN   = 3'h1,
        DM_RES_UP  = 3'h2,
        DM_RES_DN  = 3'h3,
        DM_OD_LO   = 3'h4,
        DM_OD_HI   = 3'h5,
        DM_STRONG  = 3'h6,
        DM_RES_UD  = 3'h7
    } ppd_mode_type;

    typedef enum logic [1:0] {
        EDGE_OFF  = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } ppd_edge_type;

    // Port-wide registers
    localparam logic [AW-1:0] ADDR_DM0    = 5'h00;
    localparam logic [AW-1:0] ADDR_DM1    = 5'h01;
    localparam logic [AW-1:0] ADDR_DM2    = 5'h02;
    localparam logic [AW-1:0] ADDR_DR     = 5'h03;
    localparam logic [AW-1:0] ADDR_PS     = 5'h04;
    localparam logic [AW-1:0] ADDR_SLW    = 5'h05;
    localparam logic [AW-1:0] ADDR_BYP    = 5'h06;
    localparam logic [AW-1:0] ADDR_INEN   = 5'h07;
    localparam logic [AW-1:0] ADDR_BIE    = 5'h08;
    localparam logic [AW-1:0] ADDR_IRISE  = 5'h09;
    localparam logic [AW-1:0] ADDR_IFALL  = 5'h0a;
    localparam logic [AW-1:0] ADDR_ISTAT  = 5'h0b;
    localparam logic [AW-1:0] ADDR_USB    = 5'h0c;
    localparam logic [AW-1:0] ADDR_SIOREG = 5'h0d;
    localparam logic [AW-1:0] ADDR_AUXLO  = 5'h0e;
    localparam logic [AW-1:0] ADDR_AUXHI  = 5'h0f;
    // Per-pin registers at base plus pin index
    localparam logic [AW-1:0] ADDR_PIN0   = 5'h10;

    // Per-pin register field positions
    localparam int PF_DR   = 0;
    localparam int PF_PS   = 1;
    localparam int PF_DM   = 2;
    localparam int PF_SLW  = 5;
    localparam int PF_BYP  = 6;
    localparam int PF_BIE  = 7;

    // USB control register fields
    localparam int UF_DRV  = 0;
    localparam int UF_PULL = 2;
    localparam int UF_DR   = 4;
    localparam int UF_MODE = 6;

    localparam logic [7:0] RST_ZERO = 8'h00;

endpackage : ppd_pkg

// ==== inc/ppd_pin_if.sv ====
// Interface: per-pin configuration handed from register file to pad decoder
`timescale 1ns/1ps
interface ppd_pin_if;
    logic [2:0] mode;
    logic       out_val;
    logic       slow;
    logic       regulated;
    logic       drv_strong_oe;
    logic       drv_strong_val;
    logic       pull_up;
    logic       pull_dn;
    logic       in_en;
    logic       slow_eff;
    modport cfg (output mode, out_val, slow, regulated,
                 input drv_strong_oe, drv_strong_val, pull_up, pull_dn,
                 in_en, slow_eff);
    modport dec (input mode, out_val, slow, regulated,
                 output drv_strong_oe, drv_strong_val, pull_up, pull_dn,
                 in_en, slow_eff);
endinterface : ppd_pin_if

// ==== core/ppd_pad_dec.sv ====
// Module: decodes a drive-mode code and output value into pad enables
`timescale 1ns/1ps
module ppd_pad_dec
    import ppd_pkg::*;
(
    ppd_pin_if.dec p    // Pin configuration and pad enables
);
    logic res_mode;
    logic res_ok;

    assign res_mode = (p.mode == DM_RES_UP) || (p.mode == DM_RES_DN) ||
                      (p.mode == DM_RES_UD);
    assign res_ok   = !p.regulated;

    always_comb begin
        p.drv_strong_oe  = 1'b0;
        p.drv_strong_val = p.out_val;
        p.pull_up        = 1'b0;
        p.pull_dn        = 1'b0;
        p.in_en          = 1'b1;
        unique case (p.mode)
            DM_ANALOG: p.in_en = 1'b0;
            DM_DIGIN: p.in_en = 1'b1;
            DM_RES_UP: begin
                p.drv_strong_oe = !p.out_val;
                p.pull_up       = p.out_val && res_ok;
            end
            DM_RES_DN: begin
                p.drv_strong_oe = p.out_val;
                p.pull_dn       = !p.out_val && res_ok;
            end
            DM_OD_LO: p.drv_strong_oe = !p.out_val;
            DM_OD_HI: p.drv_strong_oe = p.out_val;
            DM_STRONG: p.drv_strong_oe = 1'b1;
            DM_RES_UD: begin
                p.pull_up = p.out_val && res_ok;
                p.pull_dn = !p.out_val && res_ok;
            end
        endcase
    end

    assign p.slow_eff = p.slow && !res_mode;

endmodule : ppd_pad_dec

// ==== core/ppd_port.sv ====
// Module: eight-pin port with drive decode, USB pin pair and edge interrupts
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ppd_port
    import ppd_pkg::*;
#(
    parameter int NP = NPINS
) (
    input  wire logic             SYS_CLK,       // System clock, 200 MHz
    input  wire logic             RST,           // Synchronous reset
    input  wire logic [AW-1:0]    ADDR,          // Register address
    input  wire logic [7:0]       WDATA,         // Write data
    input  wire logic             WR,            // Write strobe
    input  wire logic             RD,            // Read strobe
    output logic      [7:0]       RDATA,         // Read data, next cycle
    input  wire logic [NP-1:0]    PIN_IN,        // Pad input levels
    output logic      [NP-1:0]    PIN_OUT,       // Strong driver level
    output logic      [NP-1:0]    PIN_OE,        // Strong driver enable
    output logic      [NP-1:0]    PIN_PU,        // Resistive pull-up on
    output logic      [NP-1:0]    PIN_PD,        // Resistive pull-down on
    output logic      [NP-1:0]    PIN_IE,        // Input buffer enable
    output logic      [NP-1:0]    PIN_SLOW,      // Slow edge select
    input  wire logic [NP-1:0]    FAB_OUT,       // Fabric output values
    output logic      [NP-1:0]    FAB_IN,        // Pin inputs to fabric
    input  wire logic [NAUX-1:0]  AUX_OE,        // Aux output enables
    input  wire logic [1:0]       USB_IN,        // USB pin pad inputs
    output logic      [1:0]       USB_OUT,       // USB pin driver level
    output logic      [1:0]       USB_OE,        // USB pin driver enable
    output logic      [1:0]       USB_PU,        // USB pin pull-up
    output logic      [1:0]       USB_PS,        // USB pin sampled state
    output logic                  IRQ            // Port interrupt request
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [NP-1:0] dm0_r, dm1_r, dm2_r, dr_r, slw_r, byp_r, inen_r, bie_r;
    logic [NP-1:0] dm0_nxt, dm1_nxt, dm2_nxt, dr_nxt, slw_nxt, byp_nxt;
    logic [NP-1:0] bie_nxt;
    logic [NP-1:0] irise_r, ifall_r, sioreg_r;
    logic [NP-1:0] stat_r, stat_nxt;
    logic [NP-1:0] sync1_r, sync2_r, prev_r;
    logic [7:0]    usb_r, usb_nxt;
    logic [1:0]    usb_s1_r, usb_s2_r;
    logic [7:0]    rdata_r, rdata_nxt;
    logic [7:0]    aux_lo_r, aux_hi_r;
    logic [NP-1:0] fab_in_r, oe_r, out_r, pu_r, pd_r, ie_r, slow_r;
    logic [1:0]    uoe_r, uout_r, upu_r;
    logic          irq_r;

    logic          wr_pin;
    logic [2:0]    pin_sel;
    logic          rd_stat;

    assign wr_pin  = WR && (ADDR[AW-1:3] == ADDR_PIN0[AW-1:3]);
    assign pin_sel = ADDR[2:0];
    assign rd_stat = RD && (ADDR == ADDR_ISTAT);

    ////////////////////////////////////////////////////////////////////////
    // Port-wide and per-pin writes onto the same state

    always_comb begin
        dm0_nxt = dm0_r;
        dm1_nxt = dm1_r;
        dm2_nxt = dm2_r;
        dr_nxt  = dr_r;
        slw_nxt = slw_r;
        byp_nxt = byp_r;
        bie_nxt = bie_r;
        if (WR) begin
            unique case (ADDR)
                ADDR_DM0: dm0_nxt = WDATA[NP-1:0];
                ADDR_DM1: dm1_nxt = WDATA[NP-1:0];
                ADDR_DM2: dm2_nxt = WDATA[NP-1:0];
                ADDR_DR:  dr_nxt  = WDATA[NP-1:0];
                ADDR_SLW: slw_nxt = WDATA[NP-1:0];
                ADDR_BYP: byp_nxt = WDATA[NP-1:0];
                ADDR_BIE: bie_nxt = WDATA[NP-1:0];
                default: ;
            endcase
        end
        if (wr_pin) begin
            dr_nxt[pin_sel]  = WDATA[PF_DR];
            dm0_nxt[pin_sel] = WDATA[PF_DM];
            dm1_nxt[pin_sel] = WDATA[PF_DM+1];
            dm2_nxt[pin_sel] = WDATA[PF_DM+2];
            slw_nxt[pin_sel] = WDATA[PF_SLW];
            byp_nxt[pin_sel] = WDATA[PF_BYP];
            bie_nxt[pin_sel] = WDATA[PF_BIE];
        end
    end

    // USB bits only via own register
    always_comb begin
        usb_nxt = usb_r;
        if (WR && ADDR == ADDR_USB) begin
            usb_nxt = WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation and edge detection

    logic [NP-1:0] rise, fall, hit;
    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;
    assign hit  = (rise & irise_r) | (fall & ifall_r);

    assign stat_nxt = (rd_stat ? '0 : stat_r) | hit;

    ////////////////////////////////////////////////////////////////////////
    // Per-pin pad decode

    logic [NP-1:0] dec_oe, dec_val, dec_pu, dec_pd, dec_ie, dec_slow;
    logic [NP-1:0] aux_en;
    logic [NAUX-1:0] aux_sel_w;
    logic [NP-1:0] out_src;

    assign out_src = (byp_r & FAB_OUT) | (~byp_r & dr_r);
    assign aux_sel_w = {aux_hi_r, aux_lo_r};

    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_pin
            ppd_pin_if pif ();
            logic oe_sel;
            assign oe_sel      = AUX_OE[aux_sel_w[2*g+1 -: 2] * 4 + g % 4];
            assign pif.mode    = {dm2_r[g], dm1_r[g], dm0_r[g]};
            assign pif.out_val = out_src[g];
            assign pif.slow    = slw_r[g];
            assign pif.regulated = sioreg_r[g];
            ppd_pad_dec u_dec (.p(pif.dec));
            assign aux_en[g]   = !bie_r[g] || oe_sel;
            assign dec_oe[g]   = pif.drv_strong_oe && aux_en[g];
            assign dec_val[g]  = pif.drv_strong_val;
            assign dec_pu[g]   = pif.pull_up && aux_en[g];
            assign dec_pd[g]   = pif.pull_dn && aux_en[g];
            assign dec_ie[g]   = pif.in_en || (bie_r[g] && !oe_sel);
            assign dec_slow[g] = pif.slow_eff;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // USB-capable pin pair

    logic [1:0] u_drv, u_pull, u_dr, u_oe, u_pu;
    logic       u_usbmode;
    assign u_drv     = usb_r[UF_DRV +: 2];
    assign u_pull    = usb_r[UF_PULL +: 2];
    assign u_dr      = usb_r[UF_DR +: 2];
    assign u_usbmode = usb_r[UF_MODE];
    assign u_oe = u_usbmode ? 2'h0 : (u_drv | ~u_dr);
    assign u_pu = u_usbmode ? 2'h0 : (u_pull & ~u_drv & u_dr);

    ////////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        rdata_nxt = 8'h00;
        if (RD) begin
            unique case (ADDR)
                ADDR_DM0:    rdata_nxt = dm0_r;
                ADDR_DM1:    rdata_nxt = dm1_r;
                ADDR_DM2:    rdata_nxt = dm2_r;
                ADDR_DR:     rdata_nxt = dr_r;
                ADDR_PS:     rdata_nxt = sync2_r;
                ADDR_SLW:    rdata_nxt = slw_r;
                ADDR_BYP:    rdata_nxt = byp_r;
                ADDR_INEN:   rdata_nxt = inen_r;
                ADDR_BIE:    rdata_nxt = bie_r;
                ADDR_IRISE:  rdata_nxt = irise_r;
                ADDR_IFALL:  rdata_nxt = ifall_r;
                ADDR_ISTAT:  rdata_nxt = stat_r;
                ADDR_USB:    rdata_nxt = usb_r;
                ADDR_SIOREG: rdata_nxt = sioreg_r;
                ADDR_AUXLO:  rdata_nxt = aux_lo_r;
                ADDR_AUXHI:  rdata_nxt = aux_hi_r;
                default: begin
                    if (ADDR[AW-1:3] == ADDR_PIN0[AW-1:3]) begin
                        rdata_nxt = {bie_r[pin_sel], byp_r[pin_sel],
                                     slw_r[pin_sel], dm2_r[pin_sel],
                                     dm1_r[pin_sel], dm0_r[pin_sel],
                                     sync2_r[pin_sel], dr_r[pin_sel]};
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            dm0_r <= RST_ZERO; dm1_r <= RST_ZERO; dm2_r <= RST_ZERO;
            dr_r  <= RST_ZERO; slw_r <= RST_ZERO; byp_r <= RST_ZERO;
            bie_r <= RST_ZERO; usb_r <= RST_ZERO;
        end else begin
            dm0_r <= dm0_nxt; dm1_r <= dm1_nxt; dm2_r <= dm2_nxt;
            dr_r  <= dr_nxt;  slw_r <= slw_nxt; byp_r <= byp_nxt;
            bie_r <= bie_nxt; usb_r <= usb_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            irise_r  <= RST_ZERO; ifall_r  <= RST_ZERO;
            inen_r   <= RST_ZERO; sioreg_r <= RST_ZERO;
            aux_lo_r <= RST_ZERO; aux_hi_r <= RST_ZERO;
        end else if (WR) begin
            if (ADDR == ADDR_IRISE)  irise_r  <= WDATA;
            if (ADDR == ADDR_IFALL)  ifall_r  <= WDATA;
            if (ADDR == ADDR_INEN)   inen_r   <= WDATA;
            if (ADDR == ADDR_SIOREG) sioreg_r <= WDATA;
            if (ADDR == ADDR_AUXLO)  aux_lo_r <= WDATA;
            if (ADDR == ADDR_AUXHI)  aux_hi_r <= WDATA;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sync1_r  <= RST_ZERO; sync2_r  <= RST_ZERO; prev_r <= RST_ZERO;
            usb_s1_r <= 2'h0;     usb_s2_r <= 2'h0;
            stat_r   <= RST_ZERO; irq_r    <= 1'b0;
        end else begin
            sync1_r  <= PIN_IN;   sync2_r  <= sync1_r; prev_r <= sync2_r;
            usb_s1_r <= USB_IN;   usb_s2_r <= usb_s1_r;
            stat_r   <= stat_nxt;
            irq_r    <= |stat_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rdata_r <= 8'h00; fab_in_r <= RST_ZERO;
            oe_r <= RST_ZERO; out_r <= RST_ZERO; pu_r <= RST_ZERO;
            pd_r <= RST_ZERO; ie_r <= RST_ZERO; slow_r <= RST_ZERO;
            uoe_r <= 2'h0; uout_r <= 2'h0; upu_r <= 2'h0;
        end else begin
            rdata_r  <= rdata_nxt;
            fab_in_r <= sync2_r & inen_r;
            oe_r <= dec_oe; out_r <= dec_val; pu_r <= dec_pu;
            pd_r <= dec_pd; ie_r <= dec_ie; slow_r <= dec_slow;
            uoe_r <= u_oe; uout_r <= u_dr; upu_r <= u_pu;
        end
    end

    assign RDATA    = rdata_r;
    assign FAB_IN   = fab_in_r;
    assign PIN_OE   = oe_r;
    assign PIN_OUT  = out_r;
    assign PIN_PU   = pu_r;
    assign PIN_PD   = pd_r;
    assign PIN_IE   = ie_r;
    assign PIN_SLOW = slow_r;
    assign USB_OE   = uoe_r;
    assign USB_OUT  = uout_r;
    assign USB_PU   = upu_r;
    assign USB_PS   = usb_s2_r;
    assign IRQ      = irq_r;

endmodule : ppd_port

// ==== bench/ppd_port_assertions.sv ====
// Checker: timing and exclusion properties on the port block pins
`timescale 1ns/1ps
module ppd_port_assertions
    import ppd_pkg::*;
#(
    parameter int NP = NPINS
) (
    input wire logic          SYS_CLK,  // Clock
    input wire logic          RST,      // Sync reset
    input wire logic [AW-1:0] ADDR,     // Address
    input wire logic          RD,       // Read strobe
    input wire logic [7:0]    RDATA,    // Read data
    input wire logic [NP-1:0] PIN_IN,   // Pad inputs
    input wire logic [NP-1:0] PIN_OE,   // Driver enable
    input wire logic [NP-1:0] PIN_PU,   // Pull-up
    input wire logic [NP-1:0] PIN_PD,   // Pull-down
    input wire logic [NP-1:0] PIN_IE,   // Input enable
    input wire logic [NP-1:0] PIN_SLOW, // Slow edge
    input wire logic [1:0]    USB_OE,   // USB driver enable
    input wire logic [1:0]    USB_PU,   // USB pull-up
    input wire logic          IRQ       // Interrupt
);
    logic stat_rd;
    assign stat_rd = RD && (ADDR == ADDR_ISTAT);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////
    // reset idles pads
    a_reset_quiet: assert property (disable iff (1'b0)
        RST |=> (PIN_OE | PIN_PU | PIN_PD | PIN_IE) == {NP{1'b0}})
        else $error("pads active after reset");
    a_drive_pull_excl: assert property (
        (PIN_OE & (PIN_PU | PIN_PD)) == {NP{1'b0}})
        else $error("driver and pull on together");
    a_pull_pair_excl: assert property ((PIN_PU & PIN_PD) == {NP{1'b0}})
        else $error("pull-up and pull-down together");
    a_slow_strong_only: assert property (
        (PIN_SLOW & (PIN_PU | PIN_PD)) == {NP{1'b0}})
        else $error("slow edge on resistive pin");
    a_usb_pull_excl: assert property ((USB_PU & USB_OE) == 2'h0)
        else $error("USB pull with driver");
    a_irq_cause: assert property ($rose(IRQ) |->
        ($past(PIN_IN, 2) != $past(PIN_IN, 3)) ||
        ($past(PIN_IN, 3) != $past(PIN_IN, 4)) ||
        ($past(PIN_IN, 4) != $past(PIN_IN, 5)))
        else $error("request without pin edge");
    a_irq_hold: assert property ($fell(IRQ) |->
        $past(stat_rd, 1) || $past(stat_rd, 2))
        else $error("request dropped without status read");
    a_stat_nonzero: assert property (
        stat_rd && IRQ && !$past(stat_rd) |=> RDATA != 8'h00)
        else $error("status empty while request high");
    // Read data quiet outside read reply
    a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data outside reply cycle");
endmodule : ppd_port_assertions

bind ppd_port ppd_port_assertions #(.NP(NP)) u_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
    .PIN_IN(PIN_IN), .PIN_OE(PIN_OE), .PIN_PU(PIN_PU), .PIN_PD(PIN_PD),
    .PIN_IE(PIN_IE), .PIN_SLOW(PIN_SLOW), .USB_OE(USB_OE),
    .USB_PU(USB_PU), .IRQ(IRQ));

// ==== bench/ppd_pin_model.sv ====
// Model: loads and outside drivers on the eight port pins
`timescale 1ns/1ps
module ppd_pin_model (
    input  wire logic       sys_clk,  // Bench clock
    input  wire logic [7:0] pad_out,  // Strong level
    input  wire logic [7:0] pad_oe,   // Strong enable
    input  wire logic [7:0] pad_pu,   // Pull-up
    input  wire logic [7:0] pad_pd,   // Pull-down
    input  wire logic [7:0] ext_en,   // Outside driver on
    input  wire logic [7:0] ext_val,  // Outside level
    output logic      [7:0] pad_lvl   // Level seen at the pad
);
    logic [7:0] flt_r = 8'h00;
    // Undriven pads wander so a stale level never passes
    always @(posedge sys_clk) begin
        flt_r <= ~flt_r;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (ext_en[i]) pad_lvl[i] = ext_val[i];
            else if (pad_oe[i]) pad_lvl[i] = pad_out[i];
            else if (pad_pu[i]) pad_lvl[i] = 1'b1;
            else if (pad_pd[i]) pad_lvl[i] = 1'b0;
            else pad_lvl[i] = flt_r[i];
        end
    end
endmodule : ppd_pin_model

// ==== bench/ppd_port_bench.sv ====
// Bench: register-level tests of the eight-pin port block
`timescale 1ns/1ps
module ppd_port_bench
    import ppd_pkg::*;
;
    logic          sys_clk, rst, wr_stb, rd_stb;
    logic [AW-1:0] addr;
    logic [7:0]    wdata, fab_out, ext_en, ext_val;
    logic [15:0]   aux_oe;
    logic [1:0]    usb_in, uc;
    logic [2:0]    md;
    logic [5:0]    usv;
    wire  [7:0]    rdata, pin_in, pin_out, pin_oe, pin_pu, pin_pd;
    wire  [7:0]    pin_ie, pin_slow, fab_in;
    wire  [1:0]    usb_out, usb_oe, usb_pu, usb_ps;
    wire           irq;
    int            err_count, samples_checked;

    ppd_port #(.NP(8)) u_dut (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr_stb), .RD(rd_stb), .RDATA(rdata),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PIN_PU(pin_pu), .PIN_PD(pin_pd), .PIN_IE(pin_ie),
        .PIN_SLOW(pin_slow), .FAB_OUT(fab_out), .FAB_IN(fab_in),
        .AUX_OE(aux_oe), .USB_IN(usb_in), .USB_OUT(usb_out),
        .USB_OE(usb_oe), .USB_PU(usb_pu), .USB_PS(usb_ps), .IRQ(irq));
    ppd_pin_model u_load (.sys_clk(sys_clk), .pad_out(pin_out),
        .pad_oe(pin_oe), .pad_pu(pin_pu), .pad_pd(pin_pd),
        .ext_en(ext_en), .ext_val(ext_val), .pad_lvl(pin_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [7:0] e, m,
                      input string nm);
        @(posedge sys_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(negedge sys_clk);
        chk(nm, e & m, rdata & m);
    endtask : rd

    task automatic gap(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : gap

    // Pad enables as {oe, out, pu, pd, ie}
    function automatic logic [4:0] pad_exp(input logic [2:0] m, input logic dv);
        case (m)
            3'h0: return 5'h00;
            3'h1: return 5'h01;
            3'h2: return dv ? 5'h05 : 5'h11;
            3'h3: return dv ? 5'h19 : 5'h03;
            3'h4: return dv ? 5'h01 : 5'h11;
            3'h5: return dv ? 5'h19 : 5'h01;
            3'h6: return {1'b1, dv, 3'h0};
            default: return dv ? 5'h05 : 5'h03;
        endcase
    endfunction : pad_exp

    task automatic pads(input logic [2:0] m, input logic [7:0] dv);
        logic [7:0] eo, ev, eu, ed, ei;
        for (int i = 0; i < 8; i++) begin
            {eo[i], ev[i], eu[i], ed[i], ei[i]} = pad_exp(m, dv[i]);
        end
        chk("oe", eo, pin_oe);
        chk("out", ev & eo, pin_out & pin_oe);
        chk("pu", eu, pin_pu);
        chk("pd", ed, pin_pd);
        // Input use in strong mode is left open
        if (m != 3'h6) chk("ie", ei, pin_ie);
    endtask : pads

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // About 200 cycles of tests; a hundred times that means a hang
    initial begin
        #100000;
        err_count++;
        summarize();
    end

    initial begin
        {rst, wr_stb, rd_stb, addr, wdata} = {3'h4, 5'h00, 8'h00};
        {fab_out, aux_oe, usb_in} = {8'ha5, 16'h0000, 2'h2};
        {ext_en, ext_val, err_count, samples_checked} = '0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        gap(1);
        pads(3'h0, 8'h00);
        rd(ADDR_ISTAT, 8'h00, 8'hff, "status");
        wr(ADDR_SLW, 8'hff);
        wr(ADDR_DR, 8'h55);
        for (int m = 0; m < 8; m++) begin
            md = m[2:0];
            wr(ADDR_DM0, {8{md[0]}});
            wr(ADDR_DM1, {8{md[1]}});
            wr(ADDR_DM2, {8{md[2]}});
            gap(2);
            pads(md, 8'h55);
            if (md > 3'h1) chk("slow", md[2] ^ (md == 3'h7) ? 8'hff : 8'h00, pin_slow);
        end
        wr(ADDR_SIOREG, 8'hff);
        gap(2);
        chk("pull reg", 8'h00, pin_pu | pin_pd);
        wr(ADDR_SIOREG, 8'h00);
        wr(ADDR_DM0, 8'h00);
        wr(ADDR_DM1, 8'h00);
        wr(ADDR_DM2, 8'h00);
        wr(ADDR_PIN0 + 5'h03, 8'h39);
        rd(ADDR_DM1, 8'h08, 8'hff, "dm1");
        rd(ADDR_DR, 8'h5d, 8'hff, "dr");
        chk("oe pin", 8'h08, pin_oe);
        chk("slow pin", 8'h08, pin_slow & 8'h08);
        wr(ADDR_DM0, 8'hff);
        rd(ADDR_PIN0 + 5'h03, 8'h3d, 8'hfd, "pin3");
        wr(ADDR_DM0, 8'h00);
        wr(ADDR_DM1, 8'hff);
        wr(ADDR_BYP, 8'hff);
        wr(ADDR_INEN, 8'hff);
        gap(4);
        chk("fab out", 8'ha5, pin_out);
        chk("fab in", 8'ha5, fab_in);
        rd(ADDR_PS, 8'ha5, 8'hff, "state");
        wr(ADDR_BIE, 8'hff);
        aux_oe <= 16'h0005;
        gap(2);
        // Resistive-high pins with a live enable still leave the driver off
        chk("bidir oe", 8'h50, pin_oe);
        chk("bidir ie", 8'haa, pin_ie & 8'haa);
        wr(ADDR_AUXLO, 8'hff);
        wr(ADDR_AUXHI, 8'hff);
        aux_oe <= 16'ha000;
        gap(2);
        chk("aux oe", 8'h0a, pin_oe);
        for (int c = 0; c < 4; c++) begin
            uc = c[1:0];
            wr(ADDR_USB, {4'h1, {2{uc[1]}}, {2{uc[0]}}});
            gap(2);
            chk("usb oe", {6'h00, 1'b1, uc[0]}, {6'h00, usb_oe});
            chk("usb pu", {7'h00, uc[1] & ~uc[0]}, {6'h00, usb_pu});
            chk("usb out", {7'h00, uc[0]}, {6'h00, usb_out & usb_oe});
        end
        wr(ADDR_USB, 8'h50);
        gap(2);
        usv = {usb_oe, usb_pu, usb_out};
        wr(ADDR_USB, 8'h5f);
        gap(2);
        chk("usb mode", {2'h0, usv}, {2'h0, usb_oe, usb_pu, usb_out});
        wr(ADDR_USB, 8'h15);
        ext_en <= 8'hff;
        wr(ADDR_DM0, 8'hff);
        wr(ADDR_DM1, 8'h00);
        wr(ADDR_DM2, 8'h00);
        rd(ADDR_USB, 8'h15, 8'hff, "usb ctl");
        chk("usb ps", 8'h02, {6'h00, usb_ps});
        wr(ADDR_BIE, 8'h00);
        wr(ADDR_IRISE, 8'h05);
        wr(ADDR_IFALL, 8'h06);
        rd(ADDR_ISTAT, 8'h00, 8'hff, "status");
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            ext_val <= (k == 0) ? 8'h0f : 8'h00;
            gap(6);
            chk("irq", 8'h01, {7'h00, irq});
            rd(ADDR_ISTAT, (k == 0) ? 8'h05 : 8'h06, 8'hff, "status");
            gap(2);
            chk("irq", 8'h00, {7'h00, irq});
            rd(ADDR_ISTAT, 8'h00, 8'hff, "status");
        end
        summarize();
    end
endmodule : ppd_port_bench
